// file: dv/hmsc_monitor.sv
`timescale 1ns/1ps
module hmsc_monitor
(
    input wire       clock,
    input wire       rst_n,
    input wire       hardware_mode,
    input wire       config_valid,
    input wire [1:0] rx_select_pins,
    input wire [7:0] receiver_control_0,
    input wire [7:0] receiver_control_1,
    input wire [7:0] input_select_control,
    input wire [7:0] serial_output_format,
    input wire [7:0] error_mask
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire hw_on = hardware_mode && config_valid;
    chk_fixed_ctrl: assert property (hw_on |-> (receiver_control_0 & 8'hf7) == 8'h00
        && (receiver_control_1 & 8'h7d) == 8'h00) else $error("control bits not fixed");
    chk_insel_fixed: assert property (hw_on |-> input_select_control[7:5] == 3'h4
        && !input_select_control[2]) else $error("input select fixed bits wrong");
    chk_live_select: assert property (hw_on && $past(config_valid)
        |-> input_select_control[4:3] == $past(rx_select_pins)) else $error("select lags");
    chk_config_hold: assert property (hw_on && $past(config_valid) |-> $stable(error_mask)
        && $stable(serial_output_format) && $stable(receiver_control_0)) else $error("changed");
    chk_swclk_hold: assert property (hw_on && receiver_control_1[7]
        |=> receiver_control_1[7]) else $error("clock switch dropped");
    chk_emask_fixed: assert property (hw_on |-> (error_mask & 8'hfb) == 8'h1b)
        else $error("error mask fixed bits wrong");
    chk_format_code: assert property (hw_on |-> serial_output_format[6:0] inside
        {7'h00, 7'h05, 7'h08, 7'h30}) else $error("format not in table");
    chk_valid_hold: assert property (config_valid |=> config_valid
        && $stable(hardware_mode)) else $error("load state lost");
endmodule // hmsc_monitor
bind hmsc_strap_config hmsc_monitor u_hmsc_monitor (.clock, .rst_n, .hardware_mode,
    .config_valid, .rx_select_pins, .receiver_control_0, .receiver_control_1,
    .input_select_control, .serial_output_format, .error_mask);

// file: dv/hmsc_strap_board.sv
`timescale 1ns/1ps
module hmsc_strap_board
(
    input  wire [7:0] pulls,
    input  wire       tx_open,
    output wire [7:0] strap
);
    // bit 0 picks the mode, the rest read their fitted resistor
    // an unfitted transmit-select pin reads its internal pull-down
    assign strap = {pulls[7:2], pulls[1] & ~tx_open, pulls[0]};
endmodule // hmsc_strap_board

// file: dv/testbench.sv
`timescale 1ns/1ps
`define CHECK(n, e, s) begin checked = checked + 1; if ((s) !== (e)) begin fails = fails + 1; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    reg        clock = 1'b0, rst_n = 1'b0, tx_open = 1'b0, sw_wr_en = 1'b0;
    reg        external_master_clock = 1'b0;
    reg  [1:0] rx_select_pins = 2'h0, tx_select_pins = 2'h0;
    reg  [6:0] sw_addr = 7'h00;
    reg  [7:0] pulls = 8'h00, sw_wdata = 8'h00;
    wire [7:0] strap, receiver_control_0, receiver_control_1, receiver_control_2;
    wire [7:0] output_pin_routing, input_select_control, serial_output_format, error_mask;
    wire       hardware_mode, config_valid;
    integer    fails = 0, checked = 0, i;
    localparam [27:0] fmt_table = {7'h30, 7'h08, 7'h05, 7'h00};
    always #50 clock = ~clock;
    hmsc_strap_board u_hmsc_strap_board (.pulls, .tx_open, .strap);
    hmsc_strap_config u_hmsc_strap_config (.clock, .rst_n, .serial_data_out_strap(strap[0]),
        .tx_select_strap(strap[1]), .user_bit_strap(strap[2]), .high_rate_strap(strap[3]),
        .cable_receiver_strap(strap[4]), .audio_strap(strap[5]), .channel_status_strap(strap[6]),
        .validity_error_strap(strap[7]), .external_master_clock, .rx_select_pins,
        .tx_select_pins, .sw_wr_en, .sw_addr, .sw_wdata, .hardware_mode, .config_valid,
        .receiver_control_0, .receiver_control_1, .receiver_control_2, .output_pin_routing,
        .input_select_control, .serial_output_format, .error_mask);
    task summarize;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task step(input integer n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task boot(input [7:0] v);
        integer k;
        begin
            pulls = v;
            rst_n = 1'b0;
            step(10);
            rst_n = 1'b1;
            for (k = 0; k < 9 && config_valid !== 1'b1; k = k + 1)
                step(1);
            if (k == 9)
            begin
                fails = fails + 1;
                summarize;
            end
        end
    endtask
    task check_formats;
        for (i = 0; i < 4; i = i + 1)
        begin
            tx_open = i[1];
            boot({i[0] ^ i[1], i[0], i[1], ~i[1], i[1], ~i[0], 1'b1, 1'b0});
            `CHECK("format", {~i[1], fmt_table[i*7 +: 7]}, serial_output_format)
            `CHECK("ctrl0", {4'h0, ~i[1], 3'h0}, receiver_control_0)
            `CHECK("ctrl1", {6'h00, ~i[0], 1'b0}, receiver_control_1)
            `CHECK("ctrl2", {1'b0, i[1], 6'h00}, receiver_control_2)
            `CHECK("emask", 8'h1b | {i[0] ^ i[1], 2'h0}, error_mask)
            pulls = ~pulls;
            step(2);
            `CHECK("held", {~i[1], fmt_table[i*7 +: 7]}, serial_output_format)
        end
    endtask
    task check_pins;
        begin
            boot(8'h00);
            rx_select_pins = 2'h2;
            tx_select_pins = 2'h1;
            sw_wr_en = 1'b1;
            sw_wdata = 8'hff;
            step(2);
            `CHECK("insel", 8'h91, input_select_control)
            `CHECK("hw write", 8'h00, receiver_control_0)
            external_master_clock = 1'b1;
            step(2);
            `CHECK("swclk", 8'h80, receiver_control_1)
        end
    endtask
    task check_soft;
        begin
            boot(8'h01);
            step(1);
            `CHECK("mode", 1'b0, hardware_mode)
            `CHECK("sw write", 8'hff, receiver_control_0)
        end
    endtask
    initial
    begin
        check_formats;
        check_pins;
        check_soft;
        summarize;
    end
endmodule // testbench

// file: hdl/hmsc_defs.vh
`ifndef HMSC_DEFS_VH
`define HMSC_DEFS_VH

// register offsets (documented port: sw_addr, the software write address)
`define HMSC_OFS_CTRL0      7'h00
`define HMSC_OFS_CTRL1      7'h01
`define HMSC_OFS_CTRL2      7'h02
`define HMSC_OFS_ROUTE      7'h03
`define HMSC_OFS_INSEL      7'h04
`define HMSC_OFS_FORMAT     7'h05
`define HMSC_OFS_EMASK      7'h06
`define HMSC_NUM_REGS       7'h07

// control 0 fields
`define HMSC_C0_FORCED_CLOCK_SWITCH_BIT  6
`define HMSC_C0_PDR_BIT     3
`define HMSC_C0_TRUNCATE_OUTPUT_BIT   2
// control 1 fields
`define HMSC_C1_SWCLK_BIT   7
`define HMSC_C1_MUTE_BIT    6
`define HMSC_C1_HOLD_MSB    3
`define HMSC_C1_HOLD_LSB    2
`define HMSC_C1_RCKF_BIT    1
`define HMSC_C1_CHS_BIT     0
// control 2 fields
`define HMSC_C2_EMPH_MSB    6
`define HMSC_C2_EMPH_LSB    4
// control 4 fields
`define HMSC_C4_RUN_BIT     7
`define HMSC_C4_RXD_BIT     6
`define HMSC_C4_RXSEL_MSB   5
`define HMSC_C4_RXSEL_LSB   3
`define HMSC_C4_TXSEL_MSB   2
`define HMSC_C4_TXSEL_LSB   0
// serial format fields
`define HMSC_SF_MASTER_BIT  7
// error mask: subcode crc, status crc, lock, conf, validity, biphase, parity
`define HMSC_EM_FIXED       8'h1b
`define HMSC_EM_VAL_BIT     2

// format code to low seven bits: rate, res[1:0], just, delay, sclk pol, lr pol
`define HMSC_FMT_LJ24       7'h00
`define HMSC_FMT_I2S24      7'h05
`define HMSC_FMT_RJ24       7'h08
`define HMSC_FMT_AES3       7'h30

`endif

// file: hdl/hmsc_strap_config.v
`timescale 1ns/1ps
`include "hmsc_defs.vh"
module hmsc_strap_config
(
    input  wire       clock,
    input  wire       rst_n,
    input  wire       serial_data_out_strap,
    input  wire       tx_select_strap,
    input  wire       user_bit_strap,
    input  wire       high_rate_strap,
    input  wire       cable_receiver_strap,
    input  wire       audio_strap,
    input  wire       channel_status_strap,
    input  wire       validity_error_strap,
    input  wire       external_master_clock,
    input  wire [1:0] rx_select_pins,
    input  wire [1:0] tx_select_pins,
    input  wire       sw_wr_en,
    input  wire [6:0] sw_addr,
    input  wire [7:0] sw_wdata,
    output reg        hardware_mode,
    output reg        config_valid,
    output reg  [7:0] receiver_control_0,
    output reg  [7:0] receiver_control_1,
    output reg  [7:0] receiver_control_2,
    output reg  [7:0] output_pin_routing,
    output reg  [7:0] input_select_control,
    output reg  [7:0] serial_output_format,
    output reg  [7:0] error_mask
);

    localparam [2:0] ST_RESET  = 3'b001;
    localparam [2:0] ST_SAMPLE = 3'b010;
    localparam [2:0] ST_RUN    = 3'b100;

    reg  [2:0] state_q;
    reg        mclk_prev_q;
    reg        mclk_seen_q;
    reg  [6:0] fmt_bits;
    wire [1:0] format_code;
    wire       load_now;
    wire       sw_write;

    assign format_code = {audio_strap, channel_status_strap};
    assign load_now    = (state_q == ST_SAMPLE);
    // software writes act only when the strap chose software mode
    assign sw_write    = (state_q == ST_RUN) && !hardware_mode && sw_wr_en;

    always @*
    begin
        case (format_code)
            2'b00:   fmt_bits = `HMSC_FMT_LJ24;
            2'b01:   fmt_bits = `HMSC_FMT_I2S24;
            2'b10:   fmt_bits = `HMSC_FMT_RJ24;
            default: fmt_bits = `HMSC_FMT_AES3;
        endcase
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RESET;
        end
        else
        begin
            case (state_q)
                ST_RESET:  state_q <= ST_SAMPLE;
                ST_SAMPLE: state_q <= ST_RUN;
                default:   state_q <= ST_RUN;
            endcase
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            mclk_prev_q <= 1'b0;
            mclk_seen_q <= 1'b0;
        end
        else
        begin
            mclk_prev_q <= external_master_clock;
            if (state_q != ST_RESET && mclk_prev_q != external_master_clock)
            begin
                mclk_seen_q <= 1'b1;
            end
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            hardware_mode        <= 1'b0;
            config_valid         <= 1'b0;
            receiver_control_0   <= 8'h00;
            receiver_control_1   <= 8'h00;
            receiver_control_2   <= 8'h00;
            output_pin_routing   <= 8'h00;
            input_select_control <= 8'h00;
            serial_output_format <= 8'h00;
            error_mask           <= 8'h00;
        end
        else if (load_now)
        begin
            hardware_mode <= !serial_data_out_strap;
            config_valid  <= 1'b1;
            if (!serial_data_out_strap)
            begin
                receiver_control_0 <= 8'h00;
                // transmit-select strap; open pin reads low
                receiver_control_0[`HMSC_C0_PDR_BIT] <= tx_select_strap;
                receiver_control_1 <= 8'h00;
                receiver_control_1[`HMSC_C1_RCKF_BIT] <= user_bit_strap;
                receiver_control_2 <= 8'h00;
                receiver_control_2[`HMSC_C2_EMPH_MSB] <= high_rate_strap;
                input_select_control <= 8'h00;
                input_select_control[`HMSC_C4_RUN_BIT] <= 1'b1;
                serial_output_format <= {cable_receiver_strap, fmt_bits};
                error_mask <= `HMSC_EM_FIXED;
                error_mask[`HMSC_EM_VAL_BIT] <= validity_error_strap;
            end
        end
        else if (hardware_mode)
        begin
            receiver_control_1[`HMSC_C1_SWCLK_BIT] <= mclk_seen_q;
            input_select_control[`HMSC_C4_RXSEL_LSB+1:`HMSC_C4_RXSEL_LSB] <= rx_select_pins;
            input_select_control[`HMSC_C4_TXSEL_LSB+1:`HMSC_C4_TXSEL_LSB] <= tx_select_pins;
        end
        else if (sw_write)
        begin
            // only the first seven offsets exist here
            if (sw_addr == `HMSC_OFS_CTRL0)
                receiver_control_0 <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_CTRL1)
                receiver_control_1 <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_CTRL2)
                receiver_control_2 <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_ROUTE)
                output_pin_routing <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_INSEL)
                input_select_control <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_FORMAT)
                serial_output_format <= sw_wdata;
            else if (sw_addr == `HMSC_OFS_EMASK)
                error_mask <= sw_wdata;
        end
    end

endmodule // hmsc_strap_config
